/* File: src/rsr_radio_status.sv */
// Radio status register bank with Avalon-MM slave and interrupt
module rsr_radio_status #(
  parameter int ADDR_W = 18
) (
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [31:0]       writedata_i,
  input  wire logic [3:0]        byteenable_i,
  output logic      [31:0]       readdata_o,
  output logic                   waitrequest_o,
  // Radio core status
  input  wire logic [7:0]        signal_strength_i,
  input  wire logic              signal_strength_update_i,
  input  wire logic [4:0]        controller_state_code_i,
  input  wire logic              crc_done_i,
  input  wire logic              crc_match_i,
  input  wire logic              carrier_sense_i,
  input  wire logic              preamble_quality_met_i,
  input  wire logic              channel_clear_i,
  input  wire logic              sync_word_i,
  input  wire logic              packet_end_i,
  input  wire logic              addr_reject_i,
  input  wire logic [7:0]        pll_cal_i,
  input  wire logic              pll_cal_update_i,
  // Interrupt
  output logic                   irq_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                input logic [15:0] idx);
    logic [ADDR_W+1:0] wide;
    wide = (ADDR_W+2)'({idx, 2'b00});
    return addr == wide[ADDR_W-1:0];
  endfunction

  function automatic logic in_rx(input logic [4:0] code);
    return code >= rsr_pkg::ST_RX_FIRST && code <= rsr_pkg::ST_RX_LAST;
  endfunction

  function automatic logic in_tx(input logic [4:0] code);
    return code >= rsr_pkg::ST_TX_FIRST && code <= rsr_pkg::ST_TX_LAST;
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  rsr_pkg::rsr_bus_type bus_reg;
  logic [7:0]  signal_strength_reg;
  logic [4:0]  state_reg;
  logic        crc_reg;
  logic        carrier_reg;
  logic        preamble_reg;
  logic        channel_reg;
  logic        sync_reg;
  logic [7:0]  pll_reg;
  logic [rsr_pkg::IRQ_WIDTH-1:0] status_reg;
  logic [rsr_pkg::IRQ_WIDTH-1:0] mask_reg;
  logic [31:0] rdata_reg;

  logic        crc_next;
  logic        sync_next;
  logic [rsr_pkg::IRQ_WIDTH-1:0] status_next;
  logic [rsr_pkg::IRQ_WIDTH-1:0] mask_next;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire req        = read_i | write_i;
  wire answering  = bus_reg == rsr_pkg::RSR_BUS_ANSWER;
  wire commit     = ce_i & answering;
  wire wr_commit  = commit & write_i & byteenable_i[0];
  wire sel_signal_strength   = hits(address_i, rsr_pkg::IDX_SIGNAL_STRENGTH);
  wire sel_state  = hits(address_i, rsr_pkg::IDX_CONTROLLER_STATE);
  wire sel_flags  = hits(address_i, rsr_pkg::IDX_PACKET_FLAGS);
  wire sel_pll    = hits(address_i, rsr_pkg::IDX_PLL_CAL_CURRENT);
  wire sel_status = hits(address_i, rsr_pkg::IDX_IRQ_STATUS);
  wire sel_mask   = hits(address_i, rsr_pkg::IDX_IRQ_MASK);

  // One wait cycle per access; the data register loads in that cycle
  assign waitrequest_o = req & ~commit;
  assign readdata_o    = rdata_reg;

  // ----------------------------------------------------------------------
  // Packet flag assembly
  // ----------------------------------------------------------------------
  wire [7:0] flags_word = {crc_reg, carrier_reg, preamble_reg,
                           channel_reg, sync_reg, 3'h0};
  wire [7:0] state_word = {3'h0, state_reg};

  wire [31:0] read_mux =
    sel_signal_strength   ? {24'h000000, signal_strength_reg}   :
    sel_state  ? {24'h000000, state_word} :
    sel_flags  ? {24'h000000, flags_word} :
    sel_pll    ? {24'h000000, pll_reg}    :
    sel_status ? {27'h0000000, status_reg} :
    sel_mask   ? {27'h0000000, mask_reg}  : 32'h00000000;

  // ----------------------------------------------------------------------
  // State transitions seen by the flags
  // ----------------------------------------------------------------------
  wire [4:0] code       = controller_state_code_i;
  wire       changed    = code != state_reg;
  wire       enter_rx   = changed & in_rx(code) & ~in_rx(state_reg);
  wire       restart_rx = changed & code == rsr_pkg::ST_RX_RESTART;
  wire       enter_ovf  = changed & code == rsr_pkg::ST_RX_OVERFLOW;
  wire       enter_unf  = changed & code == rsr_pkg::ST_TX_UNDERFLOW;

  // Early sync drop: reject only counts while receiving
  wire rx_abort = (addr_reject_i & in_rx(state_reg)) | enter_ovf;
  wire tx_abort = enter_unf & in_tx(state_reg);
  wire sync_off = packet_end_i | rx_abort | tx_abort;

  // A result arriving with the receive entry is kept: set wins
  always_comb
  begin
    crc_next = crc_reg;
    if (enter_rx | restart_rx)
    begin
      crc_next = 1'b0;
    end
    if (crc_done_i)
    begin
      crc_next = crc_match_i;
    end
  end

  always_comb
  begin
    sync_next = sync_reg;
    if (sync_off)
    begin
      sync_next = 1'b0;
    end
    if (sync_word_i)
    begin
      sync_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, write one to clear, event wins over clear
  // ----------------------------------------------------------------------
  wire [rsr_pkg::IRQ_WIDTH-1:0] events;
  assign events[rsr_pkg::IRQ_STATE_CHANGE] = changed;
  assign events[rsr_pkg::IRQ_CRC_MATCH]    = crc_done_i & crc_match_i;
  assign events[rsr_pkg::IRQ_SYNC_SEEN]    = sync_word_i;
  assign events[rsr_pkg::IRQ_PACKET_END]   = packet_end_i & sync_reg;
  assign events[rsr_pkg::IRQ_SYNC_ABORT]   = (rx_abort | tx_abort)
                                             & sync_reg;

  wire [rsr_pkg::IRQ_WIDTH-1:0] w1c =
    (wr_commit & sel_status) ? writedata_i[rsr_pkg::IRQ_WIDTH-1:0]
                             : '0;

  assign status_next = (status_reg & ~w1c) | events;
  assign mask_next   = (wr_commit & sel_mask)
                       ? writedata_i[rsr_pkg::IRQ_WIDTH-1:0] : mask_reg;
  assign irq_o       = |(status_reg & mask_reg);

  // ----------------------------------------------------------------------
  // Bus sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_reg   <= rsr_pkg::RSR_BUS_IDLE;
      rdata_reg <= 32'h00000000;
    end
    else if (ce_i)
    begin
      case (bus_reg)
        rsr_pkg::RSR_BUS_IDLE:
        begin
          if (req)
          begin
            bus_reg   <= rsr_pkg::RSR_BUS_ANSWER;
            rdata_reg <= read_i ? read_mux : 32'h00000000;
          end
        end
        rsr_pkg::RSR_BUS_ANSWER:
        begin
          bus_reg <= rsr_pkg::RSR_BUS_IDLE;
        end
        default:
        begin
          bus_reg <= rsr_pkg::RSR_BUS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sampled radio values; software writes never reach them
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      signal_strength_reg <= rsr_pkg::RST_SIGNAL_STRENGTH;
      pll_reg  <= rsr_pkg::RST_PLL_CAL_CURRENT;
    end
    else if (ce_i)
    begin
      if (signal_strength_update_i)
      begin
        signal_strength_reg <= signal_strength_i;
      end
      if (pll_cal_update_i)
      begin
        pll_reg <= pll_cal_i;
      end
    end
  end

  // Codes pass unchanged, so every documented code reads as issued
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= rsr_pkg::RST_STATE_CODE;
    end
    else if (ce_i)
    begin
      state_reg <= code;
    end
  end

  // Live indications are registered for a clean bus read
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      carrier_reg  <= 1'b0;
      preamble_reg <= 1'b0;
      channel_reg  <= 1'b0;
      crc_reg      <= 1'b0;
      sync_reg     <= 1'b0;
    end
    else if (ce_i)
    begin
      carrier_reg  <= carrier_sense_i;
      preamble_reg <= preamble_quality_met_i;
      channel_reg  <= channel_clear_i;
      crc_reg      <= crc_next;
      sync_reg     <= sync_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_reg <= '0;
      mask_reg   <= '0;
    end
    else if (ce_i)
    begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
    end
  end

endmodule

/* File: src/rsr_pkg.sv */
// Constants shared by the radio status register bank
package rsr_pkg;

  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_SIGNAL_STRENGTH   = 16'hDF3A;
  localparam logic [15:0] IDX_CONTROLLER_STATE  = 16'hDF3B;
  localparam logic [15:0] IDX_PACKET_FLAGS      = 16'hDF3C;
  localparam logic [15:0] IDX_PLL_CAL_CURRENT   = 16'hDF3D;
  localparam logic [15:0] IDX_IRQ_STATUS        = 16'hDF3E;
  localparam logic [15:0] IDX_IRQ_MASK          = 16'hDF3F;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_SIGNAL_STRENGTH = 8'h80;
  localparam logic [4:0] RST_STATE_CODE      = 5'h01;
  localparam logic [7:0] RST_PLL_CAL_CURRENT = 8'h94;

  // ----------------------------------------------------------------------
  // Packet flag bit positions
  // ----------------------------------------------------------------------
  localparam int PF_CRC_MATCH    = 7;
  localparam int PF_CARRIER      = 6;
  localparam int PF_PREAMBLE     = 5;
  localparam int PF_CHANNEL      = 4;
  localparam int PF_SYNC_FRAMING = 3;

  // ----------------------------------------------------------------------
  // Controller state codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] ST_SLEEP        = 5'h00;
  localparam logic [4:0] ST_IDLE         = 5'h01;
  localparam logic [4:0] ST_RX_FIRST     = 5'h0D;
  localparam logic [4:0] ST_RX_RESTART   = 5'h0F;
  localparam logic [4:0] ST_RX_LAST      = 5'h0F;
  localparam logic [4:0] ST_RX_OVERFLOW  = 5'h11;
  localparam logic [4:0] ST_TX_FIRST     = 5'h13;
  localparam logic [4:0] ST_TX_LAST      = 5'h14;
  localparam logic [4:0] ST_TX_UNDERFLOW = 5'h16;

  // ----------------------------------------------------------------------
  // Interrupt status bit positions
  // ----------------------------------------------------------------------
  localparam int IRQ_STATE_CHANGE = 0;
  localparam int IRQ_CRC_MATCH    = 1;
  localparam int IRQ_SYNC_SEEN    = 2;
  localparam int IRQ_PACKET_END   = 3;
  localparam int IRQ_SYNC_ABORT   = 4;
  localparam int IRQ_WIDTH        = 5;

  // Bus answer states
  typedef enum logic {RSR_BUS_IDLE, RSR_BUS_ANSWER} rsr_bus_type;

endpackage

/* File: testbench/rsr_monitor.sv */
// Port checker for the radio status register bank
module rsr_monitor #(
  parameter int ADDR_W = 18
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic              read_i,
  input wire logic              write_i,
  input wire logic [31:0]       writedata_i,
  input wire logic [3:0]        byteenable_i,
  input wire logic [31:0]       readdata_o,
  input wire logic              waitrequest_o,
  input wire logic [7:0]        signal_strength_i,
  input wire logic              signal_strength_update_i,
  input wire logic [4:0]        controller_state_code_i,
  input wire logic              irq_o
);
  default clocking mon_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire        req   = read_i || write_i;
  wire        rd_ok = read_i && !waitrequest_o;
  wire [15:0] ix    = address_i[ADDR_W-1:2];
  logic [7:0] signal_strength_reg;
  // Only the strobe loads the mirror, so a bus write that leaks shows up
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      signal_strength_reg <= 8'h80;
    else if (signal_strength_update_i && ce_i)
      signal_strength_reg <= signal_strength_i;
  end
  a_idle_no_wait: assert property (!req |-> !waitrequest_o)
    else $error("wait while idle");
  a_wait_first: assert property (req && !$past(req) |-> waitrequest_o)
    else $error("no wait cycle");
  a_answer_next: assert property (req && waitrequest_o && ce_i
    |=> !waitrequest_o || !ce_i)
    else $error("answer late");
  a_upper_zero: assert property (rd_ok |-> readdata_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_strength_held: assert property (
    rd_ok && ix == rsr_pkg::IDX_SIGNAL_STRENGTH
    |-> readdata_o[7:0] == $past(signal_strength_reg))
    else $error("strength read wrong");
  a_state_code: assert property (
    rd_ok && ix == rsr_pkg::IDX_CONTROLLER_STATE
    |-> readdata_o[7:0] == {3'b000, $past(controller_state_code_i, 2)})
    else $error("state read wrong");
  a_flags_low_zero: assert property (
    rd_ok && ix == rsr_pkg::IDX_PACKET_FLAGS |-> readdata_o[2:0] == 3'h0)
    else $error("flag bits 2:0 set");
  a_mask_quiets: assert property (write_i && !waitrequest_o
    && byteenable_i[0] && ix == rsr_pkg::IDX_IRQ_MASK
    && writedata_i[4:0] == 5'h00 |=> !irq_o)
    else $error("irq with mask clear");
endmodule

bind rsr_radio_status rsr_monitor #(.ADDR_W(ADDR_W)) u_monitor (.*);

/* File: testbench/test_radio_status_registers.sv */
// Self-checking bench for the radio status register bank
module test_radio_status_registers;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] SS = 16'hDF3A, ST = 16'hDF3B, PF = 16'hDF3C;
  localparam logic [15:0] PL = 16'hDF3D, IS = 16'hDF3E, IM = 16'hDF3F;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic        ce = 1'b1;
  logic        crc_ok = 1'b0;
  logic        waitrequest_o;
  logic        irq_o;
  logic [2:0]  lv = 3'h0;
  logic [3:0]  be = 4'hF;
  logic [4:0]  code = 5'h01;
  logic [5:0]  ev = 6'h00;
  logic [7:0]  signal_strength = 8'h00;
  logic [7:0]  pll = 8'h00;
  logic [7:0]  q;
  logic [17:0] address_i = 18'h00000;
  logic [31:0] writedata_i = 32'h00000000;
  logic [31:0] readdata_o;
  int          bad_count = 0;
  int          n_checks = 0;
  // Strobes: 5 strength, 4 crc, 3 sync, 2 end, 1 reject, 0 pll
  rsr_radio_status #(.ADDR_W(18)) u_dut (
    .clk_i, .rst_i, .ce_i(ce), .address_i, .read_i, .write_i,
    .writedata_i, .byteenable_i(be), .readdata_o, .waitrequest_o,
    .signal_strength_i(signal_strength), .signal_strength_update_i(ev[5]), .controller_state_code_i(code),
    .crc_done_i(ev[4]), .crc_match_i(crc_ok), .carrier_sense_i(lv[2]),
    .preamble_quality_met_i(lv[1]), .channel_clear_i(lv[0]),
    .sync_word_i(ev[3]), .packet_end_i(ev[2]), .addr_reject_i(ev[1]),
    .pll_cal_i(pll), .pll_cal_update_i(ev[0]), .irq_o
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Request stays put until waitrequest is seen low at a rising edge
  // Only the bench timeout ends a wait that never answers
  task automatic acc(input logic w, input logic [15:0] ix,
                     input logic [7:0] d);
    address_i <= {ix, 2'b00};
    writedata_i <= {24'h000000, d};
    read_i <= ~w;
    write_i <= w;
    do
    begin
      @(posedge clk_i);
    end
    while (waitrequest_o !== 1'b0);
    q = readdata_o[7:0];
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [7:0] exp);
    acc(1'b0, ix, 8'h00);
    chk(q, exp);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    acc(1'b1, ix, d);
  endtask
  task automatic pls(input logic [5:0] e);
    ev <= e;
    @(posedge clk_i);
    ev <= 6'h00;
    @(posedge clk_i);
  endtask
  task automatic setc(input logic [4:0] c);
    code <= c;
    @(posedge clk_i);
  endtask
  task automatic t_regs();
    rd(SS, 8'h80);
    rd(ST, 8'h01);
    rd(PF, 8'h00);
    rd(PL, 8'h94);
    wr(SS, 8'h3C);
    wr(PL, 8'h3C);
    wr(ST, 8'h1F);
    rd(SS, 8'h80);
    rd(PL, 8'h94);
    rd(ST, 8'h01);
    rd(16'hDF40, 8'h00);
    signal_strength <= 8'hC5;
    pll <= 8'h2B;
    pls(6'h21);
    rd(SS, 8'hC5);
    rd(PL, 8'h2B);
    $display("register test done");
  endtask
  task automatic t_codes();
    for (int c = 0; c < 23; c++)
    begin
      setc(5'(c));
      rd(ST, {3'b000, 5'(c)});
    end
    for (int k = 0; k < 3; k++)
    begin
      lv <= 3'h1 << k;
      setc(5'h01);
      rd(PF, {1'b0, 3'h1 << k, 4'h0});
    end
    lv <= 3'h0;
    $display("state test done");
  endtask
  task automatic t_flags();
    crc_ok <= 1'b1;
    pls(6'h10);
    rd(PF, 8'h80);
    setc(5'h0D);
    rd(PF, 8'h00);
    pls(6'h10);
    rd(PF, 8'h80);
    setc(5'h0F);
    rd(PF, 8'h00);
    crc_ok <= 1'b0;
    pls(6'h18);
    rd(PF, 8'h08);
    pls(6'h02);
    rd(PF, 8'h00);
    pls(6'h08);
    setc(5'h11);
    rd(PF, 8'h00);
    setc(5'h13);
    pls(6'h08);
    setc(5'h16);
    rd(PF, 8'h00);
    setc(5'h01);
    $display("flag test done");
  endtask
  task automatic t_irq();
    wr(IS, 8'h1F);
    wr(IM, 8'h1F);
    chk({7'h00, irq_o}, 8'h00);
    pls(6'h08);
    chk({7'h00, irq_o}, 8'h01);
    rd(IS, 8'h04);
    wr(IM, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    wr(IM, 8'h1F);
    chk({7'h00, irq_o}, 8'h01);
    wr(IS, 8'h04);
    chk({7'h00, irq_o}, 8'h00);
    pls(6'h04);
    rd(PF, 8'h00);
    rd(IS, 8'h08);
    $display("interrupt test done");
  endtask
  // Strobes while the enable is low must leave every register as it was
  task automatic t_ce();
    ce <= 1'b0;
    signal_strength <= 8'h5A;
    pls(6'h28);
    ce <= 1'b1;
    rd(SS, 8'hC5);
    rd(PF, 8'h00);
    rd(IS, 8'h08);
    be <= 4'h0;
    wr(IM, 8'h00);
    be <= 4'hF;
    rd(IM, 8'h1F);
    chk({7'h00, irq_o}, 8'h01);
    $display("enable test done");
  endtask
  // A reset in mid-run must bring back every reset value
  task automatic t_rst();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(SS, 8'h80);
    rd(ST, 8'h01);
    rd(PF, 8'h00);
    rd(PL, 8'h94);
    rd(IS, 8'h00);
    rd(IM, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    $display("reset test done");
  endtask
  initial forever #5 clk_i = ~clk_i;
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_codes();
    t_flags();
    t_irq();
    t_ce();
    t_rst();
    summarize();
  end
endmodule
